// file: include/ccr_params.svh
// Register indices, field positions, reset values and sizes of the checksum control block
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_IDX_CON0      14'h1ca2
`define CCR_IDX_CON1      14'h1ca3
`define CCR_IDX_CON2      14'h1ca4
`define CCR_IDX_DATA      14'h1c9a
`define CCR_IDX_OVERLAY   14'h1c9e
`define CCR_IDX_SCAN      14'h1cb0
`define CCR_IDX_PMD       14'h1cb1
`define CCR_IDX_STAT      14'h1cb2
`define CCR_IDX_MASK      14'h1cb3
`define CCR_CON0_EN       7
`define CCR_CON0_GO       6
`define CCR_CON0_BUSY     5
`define CCR_CON0_ZERO_AUGMENT_MODE     4
`define CCR_CON0_OVL_HI   3
`define CCR_CON0_OVL_LO   2
`define CCR_CON0_DIR      1
`define CCR_CON0_FULL     0
`define CCR_LEN_HI        4
`define CCR_SCAN_GO       0
`define CCR_PMD_CRC       0
`define CCR_PMD_SCAN      1
`define CCR_RST_CON       8'h00
`define CCR_RST_LEN       5'h00
`define CCR_RST_WORD      32'h0000_0000
`define CCR_ALL_ONES_M1   32'hffff_fffe
`define CCR_WORD_TOP      5'h1f
`endif

// file: include/ccr_pkg.sv
// Types shared by the checksum control block
package ccr_pkg;
    typedef enum logic [1:0] {
        CCR_IDLE  = 2'b00,
        CCR_SHIFT = 2'b01,
        CCR_AUG   = 2'b10
    } ccr_state_t;

    typedef enum logic [1:0] {
        CCR_OVL_OUT_A = 2'b00,
        CCR_OVL_SHIFT = 2'b01,
        CCR_OVL_XOR   = 2'b10,
        CCR_OVL_OUT_B = 2'b11
    } ccr_overlay_t;

    typedef struct packed {
        logic         en;
        logic         go;
        logic         zero_augment_mode;
        ccr_overlay_t overlay;
        logic         shift_dir;
    } ccr_ctrl_t;

    typedef struct packed {
        logic scan_md;
        logic crc_md;
    } ccr_pmd_t;

    typedef struct packed {
        logic scan_abort;
        logic word_taken;
        logic calc_done;
    } ccr_irq_t;
endpackage

// file: rtl/ccr_core.sv
// Checksum engine control, status, overlay registers and Wishbone slave
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "ccr_params.svh"

// Overview of operation
// - Sleep freezes the engine in place
// - Module disable bits stop engine, scanner separately
// - Scanner disable only honoured when scanner available
// - Enable bit releases engine, zero holds idle
// - Start bit runs shifter, zero stops it
// - Busy reads one while shifting or pending
// - Accumulator mode appends trailing zero bits
// - Overlay field picks result, shifter or polynomial
// - Direction bit: one LSb first, zero MSb
// - Full reads one until word enters shifter
// - Polynomial length field holds length minus one
// - Watchdog keeps running; software bounds scan length
// - Word length field holds length minus one
// - Clearing enable also clears scanner go
module ccr_core
#(
    parameter int ADDR_W = 16
)
(
    input  wire logic                i_ref_clk,
    input  wire logic                i_rstn,
    input  wire logic                i_wb_cyc,
    input  wire logic                i_wb_stb,
    input  wire logic                i_wb_we,
    input  wire logic [ADDR_W-1:0]   i_wb_adr,
    input  wire logic [3:0]          i_wb_sel,
    input  wire logic [31:0]         i_wb_dat,
    output logic      [31:0]         o_wb_dat,
    output logic                     o_wb_ack,
    input  wire logic                i_sleep,
    input  wire logic                i_scan_avail,
    input  wire logic                i_scan_valid,
    input  wire logic [31:0]         i_scan_data,
    input  wire logic                i_scan_done,
    output logic                     o_scan_ready,
    output logic                     o_scan_go,
    output logic                     o_irq
);
    import ccr_pkg::*;

    // Register index decode needs address bits 15:2
    if (ADDR_W < 16)
    begin
        $error("ADDR_W must be at least 16");
    end

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        return res;
    endfunction

    ccr_ctrl_t   ctrl_reg,    ctrl_next;
    logic [4:0]  poly_length_field_reg,    poly_length_field_next;
    logic [4:0]  word_length_field_reg,    word_length_field_next;
    logic [31:0] data_reg,    data_next;
    logic        full_reg,    full_next;
    logic [31:0] shifter_reg, shifter_next;
    logic [31:0] acc_reg,     acc_next;
    logic [31:0] poly_reg,    poly_next;
    ccr_state_t  state_reg,   state_next;
    logic [4:0]  bit_cnt_reg, bit_cnt_next;
    logic        scan_go_reg, scan_go_next;
    ccr_pmd_t    pmd_reg,     pmd_next;
    ccr_irq_t    stat_reg,    stat_next;
    ccr_irq_t    mask_reg,    mask_next;
    logic        ack_reg,     ack_next;
    logic [31:0] rdat_reg,    rdat_next;

    logic        wb_req;
    logic        wr_stb;
    logic [13:0] idx;
    logic        busy;
    logic        run;
    logic        held;
    logic        scan_usable;
    logic        in_bit;
    logic        fb;
    logic [31:0] len_mask;
    logic [31:0] acc_step;
    ccr_irq_t    ev;

    assign wb_req      = i_wb_cyc && i_wb_stb && !ack_reg;
    assign wr_stb      = wb_req && i_wb_we;
    assign idx         = i_wb_adr[15:2];
    assign busy        = full_reg || (state_reg != CCR_IDLE);
    assign held        = !ctrl_reg.en || pmd_reg.crc_md;
    assign run         = !held && ctrl_reg.go && !i_sleep;
    // Scanner disable has no effect on a part without a scanner
    assign scan_usable = i_scan_avail && !pmd_reg.scan_md;
    assign o_scan_go   = scan_go_reg && scan_usable;
    assign o_scan_ready = o_scan_go && run && !full_reg
                          && !(wr_stb && idx == `CCR_IDX_DATA);
    assign o_irq       = |(stat_reg & mask_reg);
    assign o_wb_ack    = ack_reg;
    assign o_wb_dat    = rdat_reg;

    // Length masks; a field of n-1 keeps n accumulator bits
    assign len_mask = ~(`CCR_ALL_ONES_M1 << poly_length_field_reg);
    assign in_bit   = (state_reg == CCR_SHIFT)
                      ? (ctrl_reg.shift_dir ? shifter_reg[0] : shifter_reg[31])
                      : 1'b0;
    assign fb       = in_bit ^ (ctrl_reg.shift_dir ? acc_reg[0] : acc_reg[poly_length_field_reg]);
    // Bits above the polynomial length must not leak into a right shift
    assign acc_step = ((ctrl_reg.shift_dir ? ((acc_reg & len_mask) >> 1) : (acc_reg << 1))
                      ^ (fb ? poly_reg : `CCR_RST_WORD)) & len_mask;

    always_comb
    begin
        ctrl_next    = ctrl_reg;
        poly_length_field_next    = poly_length_field_reg;
        word_length_field_next    = word_length_field_reg;
        data_next    = data_reg;
        full_next    = full_reg;
        shifter_next = shifter_reg;
        acc_next     = acc_reg;
        poly_next    = poly_reg;
        state_next   = state_reg;
        bit_cnt_next = bit_cnt_reg;
        scan_go_next = scan_go_reg;
        pmd_next     = pmd_reg;
        mask_next    = mask_reg;
        ev           = '0;

        // Engine step; nothing moves while asleep or stopped
        if (run)
        begin
            if (state_reg != CCR_IDLE)
            begin
                acc_next     = acc_step;
                shifter_next = ctrl_reg.shift_dir ? (shifter_reg >> 1) : (shifter_reg << 1);
                if (bit_cnt_reg != 5'd0)
                    bit_cnt_next = bit_cnt_reg - 5'd1;
                else if (state_reg == CCR_SHIFT && ctrl_reg.zero_augment_mode && !full_reg)
                begin
                    state_next   = CCR_AUG;
                    bit_cnt_next = poly_length_field_reg;
                end
                else if (!full_reg)
                begin
                    state_next    = CCR_IDLE;
                    ev.calc_done  = 1'b1;
                end
            end
            if (full_reg && (state_reg == CCR_IDLE || bit_cnt_reg == 5'd0))
            begin
                // Next word follows straight on from the last bit of this one
                shifter_next  = ctrl_reg.shift_dir ? data_reg
                                : (data_reg << (`CCR_WORD_TOP - word_length_field_reg));
                bit_cnt_next  = word_length_field_reg;
                state_next    = CCR_SHIFT;
                full_next     = 1'b0;
                ev.word_taken = 1'b1;
            end
        end

        if (o_scan_ready && i_scan_valid)
        begin
            data_next = i_scan_data;
            full_next = 1'b1;
        end
        if (i_scan_done)
            scan_go_next = 1'b0;

        if (wr_stb)
        begin
            unique case (idx)
                `CCR_IDX_CON0:
                    if (i_wb_sel[0])
                    begin
                        // Busy and full have no storage behind a write
                        ctrl_next.en        = i_wb_dat[`CCR_CON0_EN];
                        ctrl_next.go        = i_wb_dat[`CCR_CON0_GO];
                        ctrl_next.zero_augment_mode      = i_wb_dat[`CCR_CON0_ZERO_AUGMENT_MODE];
                        ctrl_next.overlay   = ccr_overlay_t'(
                            i_wb_dat[`CCR_CON0_OVL_HI:`CCR_CON0_OVL_LO]);
                        ctrl_next.shift_dir = i_wb_dat[`CCR_CON0_DIR];
                    end
                `CCR_IDX_CON1:
                    if (i_wb_sel[0])
                        poly_length_field_next = i_wb_dat[`CCR_LEN_HI:0];
                `CCR_IDX_CON2:
                    if (i_wb_sel[0])
                        word_length_field_next = i_wb_dat[`CCR_LEN_HI:0];
                `CCR_IDX_DATA:
                    if (ctrl_reg.en)
                    begin
                        data_next = lane_merge(data_reg, i_wb_dat, i_wb_sel);
                        // Low byte lane starts the word, so write it last
                        if (i_wb_sel[0])
                            full_next = 1'b1;
                    end
                `CCR_IDX_OVERLAY:
                    unique case (ctrl_reg.overlay)
                        CCR_OVL_SHIFT: shifter_next = lane_merge(shifter_reg, i_wb_dat, i_wb_sel);
                        CCR_OVL_XOR:   poly_next = lane_merge(poly_reg, i_wb_dat, i_wb_sel);
                        default:       acc_next = lane_merge(acc_reg, i_wb_dat, i_wb_sel);
                    endcase
                `CCR_IDX_SCAN:
                    if (i_wb_sel[0] && scan_usable)
                        scan_go_next = i_wb_dat[`CCR_SCAN_GO];
                `CCR_IDX_PMD:
                    if (i_wb_sel[0])
                    begin
                        pmd_next.crc_md  = i_wb_dat[`CCR_PMD_CRC];
                        pmd_next.scan_md = i_wb_dat[`CCR_PMD_SCAN];
                    end
                `CCR_IDX_MASK:
                    if (i_wb_sel[0])
                        mask_next = ccr_irq_t'(i_wb_dat[2:0]);
                default:
                    mask_next = mask_next;
            endcase
        end

        // Disabled unit drops its sequencer state and any queued word; shifter and accumulator keep their contents
        if (held)
        begin
            state_next   = CCR_IDLE;
            full_next    = 1'b0;
            bit_cnt_next = 5'd0;
        end
        // Long scans are not cut short here; the watchdog keeps counting
        // Scan go cannot be armed while the engine is off
        if (!ctrl_reg.en)
        begin
            scan_go_next  = 1'b0;
            ev.scan_abort = scan_go_reg;
        end

        // Set wins over a write-one-to-clear in the same cycle
        stat_next = stat_reg;
        if (wr_stb && idx == `CCR_IDX_STAT && i_wb_sel[0])
            stat_next = ccr_irq_t'(stat_reg & ~i_wb_dat[2:0]);
        stat_next = stat_next | ev;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            ctrl_reg    <= ccr_ctrl_t'(6'h00);
            poly_length_field_reg    <= `CCR_RST_LEN;
            word_length_field_reg    <= `CCR_RST_LEN;
            data_reg    <= `CCR_RST_WORD;
            full_reg    <= 1'b0;
            shifter_reg <= `CCR_RST_WORD;
            acc_reg     <= `CCR_RST_WORD;
            poly_reg    <= `CCR_RST_WORD;
            state_reg   <= CCR_IDLE;
            bit_cnt_reg <= 5'd0;
            scan_go_reg <= 1'b0;
            pmd_reg     <= '0;
            stat_reg    <= '0;
            mask_reg    <= '0;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            poly_length_field_reg    <= poly_length_field_next;
            word_length_field_reg    <= word_length_field_next;
            data_reg    <= data_next;
            full_reg    <= full_next;
            shifter_reg <= shifter_next;
            acc_reg     <= acc_next;
            poly_reg    <= poly_next;
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            scan_go_reg <= scan_go_next;
            pmd_reg     <= pmd_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
        end
    end

    // Bus answer: registered ack, one wait state; unmapped reads give zero
    always_comb
    begin
        ack_next  = wb_req;
        rdat_next = `CCR_RST_WORD;
        if (wb_req && !i_wb_we)
        begin
            unique case (idx)
                `CCR_IDX_CON0:    rdat_next[7:0] = {ctrl_reg.en, ctrl_reg.go, busy,
                                                    ctrl_reg.zero_augment_mode, ctrl_reg.overlay,
                                                    ctrl_reg.shift_dir, full_reg};
                `CCR_IDX_CON1:    rdat_next[4:0] = poly_length_field_reg;
                `CCR_IDX_CON2:    rdat_next[4:0] = word_length_field_reg;
                `CCR_IDX_DATA:    rdat_next = data_reg;
                `CCR_IDX_OVERLAY:
                    unique case (ctrl_reg.overlay)
                        CCR_OVL_SHIFT: rdat_next = shifter_reg;
                        CCR_OVL_XOR:   rdat_next = poly_reg;
                        default:       rdat_next = acc_reg;
                    endcase
                `CCR_IDX_SCAN:    rdat_next[0]   = scan_go_reg;
                `CCR_IDX_PMD:     rdat_next[1:0] = pmd_reg;
                `CCR_IDX_STAT:    rdat_next[2:0] = stat_reg;
                `CCR_IDX_MASK:    rdat_next[2:0] = mask_reg;
                default:          rdat_next = `CCR_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            ack_reg  <= 1'b0;
            rdat_reg <= `CCR_RST_WORD;
        end
        else
        begin
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    property p_sleep_freeze;
        i_sleep && !wr_stb && !held |=> $stable(state_reg) && $stable(bit_cnt_reg);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("engine moved in sleep");

    property p_crc_md;
        pmd_reg.crc_md |=> state_reg == CCR_IDLE && !full_reg;
    endproperty
    a_crc_md: assert property (p_crc_md) else $error("disabled engine still active");

    property p_scan_unavail;
        !i_scan_avail |-> !o_scan_go && !o_scan_ready;
    endproperty
    a_scan_unavail: assert property (p_scan_unavail) else $error("absent scanner used");

    property p_en_off;
        !ctrl_reg.en ##1 !ctrl_reg.en |-> state_reg == CCR_IDLE && !busy;
    endproperty
    a_en_off: assert property (p_en_off) else $error("engine busy while disabled");

    property p_go_off;
        !ctrl_reg.go && !wr_stb |=> $stable(shifter_reg) && $stable(acc_reg);
    endproperty
    a_go_off: assert property (p_go_off) else $error("shifter ran while stopped");

    property p_aug;
        run && state_reg == CCR_SHIFT && bit_cnt_reg == 5'd0 && !full_reg
        && ctrl_reg.zero_augment_mode && ctrl_reg.en && !pmd_reg.crc_md
        |=> state_reg == CCR_AUG && bit_cnt_reg == $past(poly_length_field_reg);
    endproperty
    a_aug: assert property (p_aug) else $error("zero augmentation missed");

    property p_full_load;
        run && full_reg && state_reg == CCR_IDLE
        |=> state_reg == CCR_SHIFT && bit_cnt_reg == $past(word_length_field_reg) ##0 busy;
    endproperty
    a_full_load: assert property (p_full_load) else $error("word not loaded");

    property p_busy_done;
        $fell(busy) && ctrl_reg.en && !pmd_reg.crc_md |-> stat_reg.calc_done;
    endproperty
    a_busy_done: assert property (p_busy_done) else $error("busy fell without done");

    property p_scan_go_clr;
        !ctrl_reg.en |=> !scan_go_reg;
    endproperty
    a_scan_go_clr: assert property (p_scan_go_clr) else $error("scan go kept");
endmodule

// file: testbench/ccr_scan_model.sv
// Behavioural memory scanner that feeds words to the checksum engine
`timescale 1ns/1ps
module ccr_scan_model
#(
    parameter int WORDS = 3
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_go,
    input  wire logic        i_ready,
    input  wire logic        i_slow,
    output logic             o_valid,
    output logic [31:0]      o_data,
    output logic             o_done
);
    int sent;
    int dly;

    initial
    begin
        o_valid = 1'b0;
        o_data  = 32'h0000_0000;
        o_done  = 1'b0;
        sent    = 0;
        dly     = 0;
    end

    // Offer is held until taken; idle data is inverted so stale words never look valid
    always @(posedge i_clk)
    begin
        o_done <= 1'b0;
        if (!i_rstn || !i_go)
        begin
            if (o_valid)
                o_data <= ~o_data;
            o_valid <= 1'b0;
            sent    <= 0;
            dly     <= 0;
        end
        else if (o_valid)
        begin
            if (i_ready)
            begin
                o_valid <= 1'b0;
                o_data  <= ~o_data;
                sent    <= sent + 1;
                dly     <= 0;
                // Scan length is bounded so it ends well before any watchdog limit
                if (sent == WORDS - 1)
                    o_done <= 1'b1;
            end
        end
        else if (sent < WORDS)
        begin
            if (dly >= (i_slow ? 12 : 0))
            begin
                o_valid <= 1'b1;
                o_data  <= {o_data[30:0], o_data[31]} ^ 32'ha5a5_0f0f;
            end
            else
                dly <= dly + 1;
        end
    end
endmodule

// file: testbench/crc_control_registers_tb.sv
// Self-checking bench for the checksum control block
`timescale 1ns/1ps
`include "ccr_params.svh"
module crc_control_registers_tb;
    import ccr_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0]  sel = 4'hf;
    logic [3:0]  lanes = 4'hf;
    logic [31:0] rdat;
    logic        ack;
    logic        sleep = 1'b0;
    logic        avail = 1'b0;
    logic        slow = 1'b0;
    logic        s_valid;
    logic [31:0] s_data;
    logic        s_done;
    logic        s_ready;
    logic        s_go;
    logic        irq;
    logic [31:0] seed = 32'h0000_000f;
    int          failures = 0;
    int          samples_checked = 0;

    always #10 clk = ~clk;

    ccr_core #(.ADDR_W(16)) DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_sleep(sleep), .i_scan_avail(avail),
        .i_scan_valid(s_valid), .i_scan_data(s_data), .i_scan_done(s_done),
        .o_scan_ready(s_ready), .o_scan_go(s_go), .o_irq(irq));

    ccr_scan_model #(.WORDS(3)) scanner (.i_clk(clk), .i_rstn(rstn), .i_go(s_go),
        .i_ready(s_ready), .i_slow(slow), .o_valid(s_valid), .o_data(s_data),
        .o_done(s_done));

    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] msk(input logic [4:0] pl);
        logic [32:0] t;
        t = (33'h1 << (pl + 1)) - 33'h1;
        return t[31:0];
    endfunction

    // Direct form: each data bit joins the feedback taken from the far end
    function automatic logic [31:0] crc_calc(input logic [31:0] acc, input logic [31:0] poly,
        input logic [31:0] data, input logic [4:0] pl, input logic [4:0] dl,
        input logic dir, input logic zero_augment_mode);
        logic [31:0] m;
        logic        fb;
        logic        d;
        int          i;
        m = msk(pl);
        acc = acc & m;
        for (i = 0; i <= dl + (zero_augment_mode ? pl + 1 : 0); i++)
        begin
            d = (i <= dl) ? (dir ? data[i] : data[dl - i]) : 1'b0;
            fb = d ^ (dir ? acc[0] : acc[pl]);
            acc = dir ? (acc >> 1) : ((acc << 1) & m);
            if (fb)
                acc = acc ^ (poly & m);
        end
        return acc;
    endfunction

    // Classic single cycle: hold until ack is seen, take data at that edge, then release
    task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= lanes;
        adr  <= {idx, 2'b00};
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50)
        begin
            failures++;
            close_out();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [13:0] idx, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0000_0000, q);
        check(q & m, e);
    endtask

    task automatic wait_idle();
        logic [31:0] q;
        int          n;
        n = 0;
        do
        begin
            bus(1'b0, `CCR_IDX_CON0, 32'h0000_0000, q);
            n++;
        end
        while (q[5] !== 1'b0 && n < 200);
        if (n >= 200)
        begin
            failures++;
            close_out();
        end
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        close_out();
    end

    initial
    begin
        logic [31:0] poly;
        logic [31:0] init;
        logic [31:0] data;
        logic [31:0] r;
        logic [31:0] m;
        logic [4:0]  pl;
        logic [4:0]  dl;
        int          k;
        int          n;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rdc(`CCR_IDX_CON0, 32'h0000_00ff, 32'h0000_0000);
        rdc(`CCR_IDX_CON1, 32'h0000_00ff, 32'h0000_0000);
        wr(`CCR_IDX_CON0, 32'h0000_0021);
        wr(`CCR_IDX_DATA, rnd());
        rdc(`CCR_IDX_CON0, 32'h0000_00ff, 32'h0000_0000);
        for (k = 0; k < 4; k++)
        begin
            r = rnd();
            pl = 5'd3 + 5'(r % 29);
            dl = (k == 0) ? 5'h1f : (k == 3) ? 5'h00 : r[12:8];
            m = msk(pl);
            poly = rnd();
            init = rnd();
            data = rnd();
            wr(`CCR_IDX_CON1, {27'h0, pl});
            wr(`CCR_IDX_CON2, {27'h0, dl});
            wr(`CCR_IDX_CON0, 32'h0000_0088);
            wr(`CCR_IDX_OVERLAY, poly);
            wr(`CCR_IDX_CON0, 32'h0000_0080);
            wr(`CCR_IDX_OVERLAY, init);
            wr(`CCR_IDX_CON0, {24'h0, 3'b100, k[1], 2'b00, k[0], 1'b0});
            // Upper lanes alone must not start the word
            lanes = (k == 2) ? 4'hc : 4'hf;
            wr(`CCR_IDX_DATA, data);
            if (k == 2)
            begin
                rdc(`CCR_IDX_CON0, 32'h0000_0001, 32'h0000_0000);
                lanes = 4'h3;
                wr(`CCR_IDX_DATA, data);
                lanes = 4'hf;
            end
            rdc(`CCR_IDX_CON0, 32'h0000_0021, 32'h0000_0021);
            if (k == 1)
                sleep <= 1'b1;
            wr(`CCR_IDX_CON0, {24'h0, 3'b110, k[1], 2'b00, k[0], 1'b0});
            if (k == 1)
            begin
                repeat (40) @(posedge clk);
                rdc(`CCR_IDX_CON0, 32'h0000_0021, 32'h0000_0021);
                sleep <= 1'b0;
            end
            wait_idle();
            rdc(`CCR_IDX_CON0, 32'h0000_0001, 32'h0000_0000);
            r = crc_calc(init, poly, data, pl, dl, k[0], k[1]);
            rdc(`CCR_IDX_OVERLAY, m, r);
            wr(`CCR_IDX_CON0, 32'h0000_008c);
            rdc(`CCR_IDX_OVERLAY, m, r);
            wr(`CCR_IDX_CON0, 32'h0000_0088);
            rdc(`CCR_IDX_OVERLAY, m, poly & m);
            wr(`CCR_IDX_CON0, 32'h0000_0000);
        end
        wr(`CCR_IDX_PMD, 32'h0000_0001);
        wr(`CCR_IDX_CON0, 32'h0000_00c0);
        wr(`CCR_IDX_DATA, rnd());
        rdc(`CCR_IDX_CON0, 32'h0000_0021, 32'h0000_0000);
        wr(`CCR_IDX_PMD, 32'h0000_0000);
        wr(`CCR_IDX_CON2, 32'h0000_001f);
        avail <= 1'b1;
        wr(`CCR_IDX_SCAN, 32'h0000_0001);
        n = 0;
        while (s_go !== 1'b0 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check({31'h0, s_go}, 32'h0000_0000);
        wait_idle();
        rdc(`CCR_IDX_STAT, 32'h0000_0007, 32'h0000_0003);
        wr(`CCR_IDX_STAT, 32'h0000_0007);
        rdc(`CCR_IDX_STAT, 32'h0000_0007, 32'h0000_0000);
        // Last table entry leaves the scanner usable and running, for the abort below
        slow <= 1'b1;
        for (k = 0; k < 4; k++)
        begin
            avail <= k[1];
            wr(`CCR_IDX_PMD, {30'h0, k[0] ^ k[1], 1'b0});
            wr(`CCR_IDX_SCAN, 32'h0000_0001);
            @(negedge clk);
            check({31'h0, s_go}, {31'h0, k[1] & k[0]});
        end
        wr(`CCR_IDX_MASK, 32'h0000_0004);
        wr(`CCR_IDX_CON0, 32'h0000_0000);
        @(negedge clk);
        check({31'h0, s_go}, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0001);
        rdc(`CCR_IDX_STAT, 32'h0000_0004, 32'h0000_0004);
        wr(`CCR_IDX_MASK, 32'h0000_0000);
        @(negedge clk);
        check({31'h0, irq}, 32'h0000_0000);
        wr(`CCR_IDX_MASK, 32'h0000_0004);
        wr(`CCR_IDX_STAT, 32'h0000_0004);
        @(negedge clk);
        check({31'h0, irq}, 32'h0000_0000);
        close_out();
    end
endmodule
